// [hdl/pcs_autoneg_resolution.sv]
/*
 * PCS auto-negotiation control with its APB register file.
 * Assumes config words arrive already decoded from the ten-bit code path
 * on this clock, and that software resolves duplex and pause itself.
 */
// Summary of operation
// [R01] Ten-bit PCS path; this block exchanges the config words of negotiation.
// [R02] Control register bit turns auto-negotiation on or off.
// [R03] Software writes advertisement register before negotiating.
// [R04] Software sets advert next-page bit to send or accept next pages.
// [R05] Control register restart bit restarts negotiation.
// [R06] Expansion page-received flag sets when partner base page arrives.
// [R07] Control register completion bit reports negotiation done.
// [R08] Partner base page, with its next-page bit, is readable.
// [R09] Software writes next-page register; device sends it; null message 0x2001.
// [R10] Partner next page sets page-received and is held for reading.
// [R11] Software repeats write, poll, read until partner next pages end.
// [R12] Next pages carry an acknowledge-2 bit both directions.
// [R13] Full duplex only when both sides advertise full duplex.
// [R14] Symmetric pause when both pause bits set, per local pattern.
// [R15] Local 0/1 with partner 1/1 enables pause transmit only.
// [R16] Local 1/1 with partner 0/1 enables pause receive only.
// [R17] Software programs MAC duplex, receive flow control, PCS duplex LED bit.
// [R18] Software alone controls pause transmission and next-page functions; pauseTxRequest here follows rxFifoAboveOn while autoPauseTx is set.
// [R19] Received pause acted on only with receive flow control enabled.
// [R20] Restart bit clears itself once the restart state is entered.
`timescale 1ns/10ps
`default_nettype none
module pcs_autoneg_resolution
   import pcs_an_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // config words from and to the ten-bit code path
   input wire pcs_an_pkg::cfg_word_t cfgIn,
   output pcs_an_pkg::cfg_word_t cfgOut,
   // mac side
   input wire logic pauseFrameRx,
   input wire logic rxFifoAboveOn,
   output logic pauseFrameActed,
   output logic pauseTxRequest,
   output logic mac_full_duplex_sel,
   output logic rx_pause_honor_en,
   output logic auto_pause_tx_en,
   output logic duplex_led_out
);
   import pcs_an_pkg::*;

   an_regs_t r;
   an_regs_t next_r;
   logic setup;
   logic access;
   logic mapped;

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign mapped = (paddr == OFS_PCS_CTRL) || (paddr == OFS_ADVERT) ||
      (paddr == OFS_EXPANSION) || (paddr == OFS_PARTNER_BASE) ||
      (paddr == OFS_LOCAL_NP) || (paddr == OFS_PARTNER_NP) || (paddr == OFS_MAC_CTRL);
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   function automatic logic [31:0] readMux(input an_regs_t s, input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0;
      if (a == OFS_PCS_CTRL)
      begin
         d[CTRL_AN_ENABLE] = s.anEnable;
         d[CTRL_RESTART] = s.restart;
         d[CTRL_COMPLETE] = s.complete; // R07
         d[CTRL_DUPLEX] = s.duplexBit;
      end
      else if (a == OFS_ADVERT)
         d[15:0] = s.advert;
      else if (a == OFS_EXPANSION)
         d[EXP_PAGE_RX] = s.pageRx;
      else if (a == OFS_PARTNER_BASE)
         d[15:0] = s.partnerBase; // R08
      else if (a == OFS_LOCAL_NP)
         d[15:0] = s.localNp;
      else if (a == OFS_PARTNER_NP)
         d[15:0] = s.partnerNp; // R10
      else if (a == OFS_MAC_CTRL)
      begin
         d[MAC_FULL_DUPLEX] = s.macFullDuplex;
         d[MAC_RX_PAUSE] = s.rxPauseHonor;
         d[MAC_TX_PAUSE] = s.autoPauseTx;
      end
      return d;
   endfunction : readMux

   always_comb
   begin
      next_r = r;
      // read data is latched in the setup cycle so the access phase needs no wait
      if (setup && !pwrite)
         next_r.prdata = readMux(r, paddr);
      // page-received clears on read; a page arriving below sets it again
      if (access && !pwrite && paddr == OFS_EXPANSION)
         next_r.pageRx = 1'b0;
      if (access && pwrite)
      begin
         if (paddr == OFS_PCS_CTRL)
         begin
            next_r.anEnable = pwdata[CTRL_AN_ENABLE]; // R02
            next_r.restart = r.restart | pwdata[CTRL_RESTART]; // R05
            next_r.duplexBit = pwdata[CTRL_DUPLEX]; // R17
         end
         else if (paddr == OFS_ADVERT)
            next_r.advert = pwdata[15:0];
         else if (paddr == OFS_LOCAL_NP)
         begin
            next_r.localNp = pwdata[15:0]; // R09
            next_r.npPending = 1'b1;
         end
         else if (paddr == OFS_MAC_CTRL)
         begin
            next_r.macFullDuplex = pwdata[MAC_FULL_DUPLEX];
            next_r.rxPauseHonor = pwdata[MAC_RX_PAUSE];
            next_r.autoPauseTx = pwdata[MAC_TX_PAUSE];
         end
      end
      // negotiation sequence
      case (r.state)
         AN_DISABLED:
            if (r.anEnable)
            begin
               next_r.state = AN_RESTART;
               next_r.timer = '0;
            end
         AN_RESTART:
         begin
            next_r.restart = 1'b0; // R20
            next_r.complete = 1'b0;
            next_r.timer = r.timer + TIMER_W'(1);
            if (r.timer == TIMER_W'(RESTART_CYCLES - 1))
               next_r.state = AN_ABILITY;
         end
         AN_ABILITY:
            if (cfgIn.valid && cfgIn.word != 16'h0)
            begin
               next_r.partnerBase = cfgIn.word; // R08
               next_r.pageRx = 1'b1; // R06
               next_r.state = AN_ACK;
            end
         AN_ACK:
            if (cfgIn.valid && cfgIn.word[PG_ACK])
            begin
               // next pages only when both sides asked for them
               if (r.advert[PG_NEXT_PAGE] && r.partnerBase[PG_NEXT_PAGE])
                  next_r.state = AN_NP_WAIT;
               else
                  next_r.state = AN_COMPLETE;
            end
         AN_NP_WAIT:
            if (r.npPending)
            begin
               next_r.npPending = next_r.npPending && (access && pwrite &&
                  paddr == OFS_LOCAL_NP);
               next_r.state = AN_NP_XCHG;
            end
         AN_NP_XCHG:
            if (cfgIn.valid)
            begin
               next_r.partnerNp = cfgIn.word; // R10
               next_r.pageRx = 1'b1; // R10
               if (!r.localNp[PG_NEXT_PAGE] && !cfgIn.word[PG_NEXT_PAGE])
                  next_r.state = AN_COMPLETE;
               else
                  next_r.state = AN_NP_WAIT;
            end
         AN_COMPLETE:
            next_r.complete = 1'b1; // R07
         default:
            next_r.state = AN_DISABLED;
      endcase
      // disable overrides every state; restart overrides every state but AN_RESTART
      if (!r.anEnable)
      begin
         next_r.state = AN_DISABLED; // R02
         next_r.complete = 1'b0;
      end
      else if (r.restart && r.state != AN_RESTART)
      begin
         next_r.state = AN_RESTART; // R05
         next_r.timer = '0;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         r <= '0;
         r.state <= AN_DISABLED;
         r.anEnable <= AN_ENABLE_RST;
         r.advert <= ADVERT_RST;
         r.localNp <= NULL_MESSAGE;
      end
      else if (ce)
         r <= next_r;
   end

   // transmitted words: idle while disabled or restarting, then pages
   always_comb
   begin
      cfgOut.valid = !(r.state == AN_DISABLED); // R01
      cfgOut.word = 16'h0;
      if (r.state == AN_ABILITY)
         cfgOut.word = r.advert;
      else if (r.state == AN_ACK || r.state == AN_NP_WAIT || r.state == AN_COMPLETE)
         cfgOut.word = r.advert | (16'h1 << PG_ACK);
      else if (r.state == AN_NP_XCHG)
         cfgOut.word = r.localNp; // R09 R12
   end

   assign prdata = r.prdata;
   assign mac_full_duplex_sel = r.macFullDuplex;
   assign rx_pause_honor_en = r.rxPauseHonor;
   assign auto_pause_tx_en = r.autoPauseTx;
   assign duplex_led_out = r.duplexBit; // R17
   assign pauseFrameActed = pauseFrameRx && r.rxPauseHonor; // R19
   assign pauseTxRequest = rxFifoAboveOn && r.autoPauseTx; // R18

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_ctrl_write;
      ce && access && pwrite && paddr == OFS_PCS_CTRL;
   endsequence
   sequence s_mac_off;
      ce && access && pwrite && paddr == OFS_MAC_CTRL && !pwdata[MAC_RX_PAUSE];
   endsequence
   sequence s_base_arrives;
      ce && r.anEnable && !r.restart && r.state == AN_ABILITY && cfgIn.valid &&
         cfgIn.word != 16'h0;
   endsequence

   a_restart_self_clear: assert property ((ce && r.state == AN_RESTART && r.anEnable &&
      !(access && pwrite && paddr == OFS_PCS_CTRL)) |=> !r.restart)
      else $error("restart bit did not clear"); // R20
   a_restart_enters: assert property ((ce && r.anEnable && r.restart &&
      r.state != AN_RESTART) |=> r.state == AN_RESTART)
      else $error("restart request not honoured"); // R05
   a_disable_idle: assert property ((ce && !r.anEnable) |=> r.state == AN_DISABLED &&
      !cfgOut.valid)
      else $error("negotiation not stopped when disabled"); // R02
   a_base_capture: assert property (s_base_arrives |=> r.pageRx &&
      r.partnerBase == $past(cfgIn.word) && r.state == AN_ACK)
      else $error("partner base page not captured"); // R06 R08
   a_complete_state: assert property ((ce && r.state == AN_COMPLETE && r.anEnable &&
      !r.restart) |=> r.complete)
      else $error("completion bit not set"); // R07
   a_np_capture: assert property ((ce && r.anEnable && !r.restart &&
      r.state == AN_NP_XCHG && cfgIn.valid) |=> r.pageRx &&
      r.partnerNp == $past(cfgIn.word))
      else $error("partner next page not held"); // R10
   a_np_sent: assert property (r.state == AN_NP_XCHG |-> cfgOut.valid &&
      cfgOut.word == r.localNp)
      else $error("local next page not transmitted"); // R09 R12
   a_led_follows: assert property (s_ctrl_write |=> duplex_led_out ==
      $past(pwdata[CTRL_DUPLEX]))
      else $error("duplex led does not follow control bit"); // R17
   a_pause_gate: assert property ((s_mac_off) |=> !pauseFrameActed)
      else $error("pause frame acted on while not enabled"); // R19
   a_restart_hold: assert property (($rose(r.state == AN_RESTART) && ce) |->
      !(r.state == AN_ABILITY) [*8])
      else $error("restart hold too short"); // R05
endmodule : pcs_autoneg_resolution
`default_nettype wire

// [hdl/pcs_an_pkg.sv]
/*
 * Constants and types for the PCS auto-negotiation control block:
 * APB register offsets, field positions, reset values, timing, states.
 * Assumes a 100 MHz clock and a 32-bit APB with byte addresses.
 */
package pcs_an_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_PCS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADVERT = 8'h04;
   localparam logic [7:0] OFS_EXPANSION = 8'h08;
   localparam logic [7:0] OFS_PARTNER_BASE = 8'h0c;
   localparam logic [7:0] OFS_LOCAL_NP = 8'h10;
   localparam logic [7:0] OFS_PARTNER_NP = 8'h14;
   localparam logic [7:0] OFS_MAC_CTRL = 8'h18;
   // pcs control fields
   localparam int CTRL_AN_ENABLE = 0;
   localparam int CTRL_RESTART = 1;
   localparam int CTRL_COMPLETE = 2;
   localparam int CTRL_DUPLEX = 3;
   // expansion field
   localparam int EXP_PAGE_RX = 1;
   // page word fields
   localparam int PG_NEXT_PAGE = 15;
   localparam int PG_ACK = 14;
   localparam int PG_ACK2 = 12;
   // mac control fields
   localparam int MAC_FULL_DUPLEX = 0;
   localparam int MAC_RX_PAUSE = 1;
   localparam int MAC_TX_PAUSE = 2;
   // advertisement ability fields, as laid out by the reset value below
   localparam int ADV_FULL_DUPLEX = 5;
   localparam int ADV_PAUSE = 7;
   localparam int ADV_ASM_DIR = 8;
   // reset values
   localparam logic AN_ENABLE_RST = 1'b1;
   localparam logic [15:0] ADVERT_RST = 16'h01a0;
   localparam logic [15:0] NULL_MESSAGE = 16'h2001;
   // restart hold: idle words sent before the ability exchange
   localparam int RESTART_HOLD_NS = 10000;
   localparam int CLOCK_NS = 10;
   localparam int RESTART_CYCLES = (RESTART_HOLD_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int TIMER_W = 16;

   typedef enum logic [6:0] {
      AN_DISABLED = 7'h01,
      AN_RESTART = 7'h02,
      AN_ABILITY = 7'h04,
      AN_ACK = 7'h08,
      AN_NP_WAIT = 7'h10,
      AN_NP_XCHG = 7'h20,
      AN_COMPLETE = 7'h40
   } an_state_t;

   // one configuration word as passed to or from the ten-bit code path
   typedef struct packed {
      logic valid;
      logic [15:0] word;
   } cfg_word_t;

   typedef struct packed {
      an_state_t state;
      logic anEnable;
      logic restart;
      logic complete;
      logic duplexBit;
      logic [15:0] advert;
      logic pageRx;
      logic [15:0] partnerBase;
      logic [15:0] localNp;
      logic npPending;
      logic [15:0] partnerNp;
      logic macFullDuplex;
      logic rxPauseHonor;
      logic autoPauseTx;
      logic [TIMER_W-1:0] timer;
      logic [31:0] prdata;
   } an_regs_t;
endpackage : pcs_an_pkg

// [tb/pcs_link_partner.sv]
/*
 * Link partner model: puts config words onto the block's receive side.
 * Assumes the words arrive decoded, one valid pulse per word, on the block clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pcs_link_partner
   import pcs_an_pkg::*;
(
   // clock
   input wire logic clock,
   // config words toward the block
   output pcs_an_pkg::cfg_word_t cfgIn
);
   import pcs_an_pkg::*;
   // idle word is the inverse, so a stale copy is never mistaken for a new word
   task automatic sendWord(input logic [15:0] w);
      @(posedge clock);
      cfgIn.valid <= 1'b1;
      cfgIn.word <= w;
      @(posedge clock);
      cfgIn.valid <= 1'b0;
      cfgIn.word <= ~w;
   endtask : sendWord

   initial
   begin
      cfgIn = '0;
   end
endmodule : pcs_link_partner
`default_nettype wire

// [tb/pcs_autoneg_resolution_test.sv]
/*
 * Self-checking bench for the auto-negotiation control block.
 * Assumes the link partner model beside it and zero-wait APB answers.
 */
`timescale 1ns/10ps
`default_nettype none
module pcs_autoneg_resolution_test;
   import pcs_an_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, acted, txReq, macFd, rxHonor, autoTx, led;
   logic pauseFrameRx = 1'b0;
   logic rxFifoAboveOn = 1'b0;
   logic ce = 1'b1;
   cfg_word_t cfgIn, cfgOut;
   int mismatches = 0;
   int n_compared = 0;

   always #5 clock = ~clock;

   pcs_autoneg_resolution i_dut (.clock(clock), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cfgIn(cfgIn), .cfgOut(cfgOut),
      .pauseFrameRx(pauseFrameRx), .rxFifoAboveOn(rxFifoAboveOn), .pauseFrameActed(acted),
      .pauseTxRequest(txReq), .mac_full_duplex_sel(macFd), .rx_pause_honor_en(rxHonor),
      .auto_pause_tx_en(autoTx), .duplex_led_out(led));
   pcs_link_partner i_partner (.clock(clock), .cfgIn(cfgIn));

   task automatic end_sim();
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic err);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         mismatches++;
         $display("Error pready expected 1 seen %b", pready);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(what, exp, q);
   endtask : rdChk

   // bounded wait on the transmitted word, then judge it
   task automatic waitWord(input logic [15:0] w);
      int n;
      n = 0;
      while (cfgOut.word !== w && n < 3000)
      begin
         @(posedge clock);
         n++;
      end
      chk("cfgOut.word", {16'h0, w}, {16'h0, cfgOut.word});
   endtask : waitWord

   // software side of priority resolution: {pause tx, pause rx, full duplex}
   function automatic logic [2:0] resolve(input logic [15:0] loc, input logic [15:0] lp);
      logic fd;
      logic tx;
      logic rx;
      fd = loc[ADV_FULL_DUPLEX] && lp[ADV_FULL_DUPLEX];
      tx = loc[ADV_PAUSE] && lp[ADV_PAUSE];
      rx = tx;
      if (!loc[ADV_PAUSE] && loc[ADV_ASM_DIR] && lp[ADV_PAUSE] && lp[ADV_ASM_DIR])
         tx = 1'b1;
      if (loc[ADV_PAUSE] && loc[ADV_ASM_DIR] && !lp[ADV_PAUSE] && lp[ADV_ASM_DIR])
         rx = 1'b1;
      return {tx, rx, fd};
   endfunction : resolve

   // expected modes are written out from the resolution tables, not from resolve
   task automatic resolveModes(input logic [15:0] loc, input logic [15:0] lp,
         input logic [2:0] exp);
      wr(OFS_MAC_CTRL, {29'h0, resolve(loc, lp)});
      @(posedge clock);
      chk("resolved", {29'h0, exp}, {29'h0, autoTx, rxHonor, macFd});
   endtask : resolveModes

   task automatic resetValues();
      logic [31:0] q;
      logic e;
      rdChk("ctrl", OFS_PCS_CTRL, 32'h1);
      rdChk("advert", OFS_ADVERT, 32'h01a0);
      rdChk("localNp", OFS_LOCAL_NP, 32'h2001);
      rdChk("mac_control_reg", OFS_MAC_CTRL, 32'h0);
      apb(1'b0, 8'h1c, 32'h0, q, e);
      chk("pslverr", 32'h1, {31'h0, e});
      chk("unmapped", 32'h0, q);
   endtask : resetValues

   task automatic basePage();
      wr(OFS_ADVERT, 32'h0180);
      waitWord(16'h0180);
      i_partner.sendWord(16'h01a0);
      waitWord(16'h4180);
      rdChk("expansion", OFS_EXPANSION, 32'h2);
      rdChk("expansion", OFS_EXPANSION, 32'h0);
      rdChk("base", OFS_PARTNER_BASE, 32'h01a0);
      i_partner.sendWord(16'h41a0);
      repeat (3) @(posedge clock);
      rdChk("ctrl", OFS_PCS_CTRL, 32'h5);
      resolveModes(16'h0180, 16'h01a0, 3'b110);
      resolveModes(16'h0100, 16'h0180, 3'b100);
      resolveModes(16'h01a0, 16'h0120, 3'b011);
   endtask : basePage

   task automatic local_next_page_reg();
      wr(OFS_ADVERT, 32'h8180);
      wr(OFS_PCS_CTRL, 32'h3);
      // restart state is entered one edge later and clears the bit on the next
      repeat (2) @(posedge clock);
      rdChk("ctrl", OFS_PCS_CTRL, 32'h1);
      chk("restart word", 32'h0, {16'h0, cfgOut.word});
      waitWord(16'h8180);
      i_partner.sendWord(16'h81a0);
      waitWord(16'hc180);
      i_partner.sendWord(16'hc1a0);
      rdChk("base", OFS_PARTNER_BASE, 32'h81a0);
      rdChk("expansion", OFS_EXPANSION, 32'h2);
      wr(OFS_LOCAL_NP, 32'h3001);
      waitWord(16'h3001);
      i_partner.sendWord(16'h1005);
      repeat (3) @(posedge clock);
      rdChk("expansion", OFS_EXPANSION, 32'h2);
      rdChk("partnerNp", OFS_PARTNER_NP, 32'h1005);
      rdChk("ctrl", OFS_PCS_CTRL, 32'h5);
   endtask : local_next_page_reg

   task automatic mac_control_reg();
      wr(OFS_MAC_CTRL, 32'h7);
      wr(OFS_PCS_CTRL, 32'h9);
      rdChk("mac_control_reg", OFS_MAC_CTRL, 32'h7);
      pauseFrameRx <= 1'b1;
      rxFifoAboveOn <= 1'b1;
      @(posedge clock);
      @(posedge clock);
      chk("mac outs", 32'h3f, {26'h0, led, macFd, rxHonor, autoTx, acted, txReq});
      wr(OFS_MAC_CTRL, 32'h0);
      wr(OFS_PCS_CTRL, 32'h1);
      @(posedge clock);
      chk("mac outs", 32'h0, {26'h0, led, macFd, rxHonor, autoTx, acted, txReq});
   endtask : mac_control_reg

   task automatic disableAn();
      wr(OFS_PCS_CTRL, 32'h0);
      repeat (2) @(posedge clock);
      chk("valid off", 32'h0, {31'h0, cfgOut.valid});
      wr(OFS_PCS_CTRL, 32'h1);
      repeat (3) @(posedge clock);
      chk("valid on", 32'h1, {31'h0, cfgOut.valid});
   endtask : disableAn

   // a write while the clock enable is low must leave the register untouched
   task automatic ceFreeze();
      ce <= 1'b0;
      wr(OFS_MAC_CTRL, 32'h7);
      repeat (2) @(posedge clock);
      chk("frozen outs", 32'h0, {29'h0, autoTx, rxHonor, macFd});
      ce <= 1'b1;
      rdChk("mac_control_reg", OFS_MAC_CTRL, 32'h0);
   endtask : ceFreeze

   initial
   begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      resetValues();
      basePage();
      local_next_page_reg();
      mac_control_reg();
      disableAn();
      ceFreeze();
      end_sim();
   end

   // about two restart holds are waited out; far more means a hang
   initial
   begin
      repeat (20000) @(posedge clock);
      mismatches++;
      end_sim();
   end
endmodule : pcs_autoneg_resolution_test
`default_nettype wire
